// ==== shared/iot_pkg.sv ====
// constants for the internal oscillator tuning block
// assumes a single core clock domain and a plain strobe register port
package iot_pkg;

  // ==========================================================================
  // register map
  localparam int          ADDR_W        = 4;
  localparam int          REG_W         = 8;
  localparam logic [3:0]  TRIM_OFS      = 4'h0;  // tuning register
  localparam logic [3:0]  STAT_OFS      = 4'h1;  // status register, read only

  // ==========================================================================
  // tuning register fields
  localparam int          SRC_BIT       = 7;     // low frequency source select
  localparam int          MULT_BIT      = 6;     // times four multiplier enable
  localparam int          TRIM_MSB      = 5;
  localparam int          TRIM_LSB      = 0;
  localparam int          TRIM_W        = 6;
  localparam logic [7:0]  TRIM_RESET    = 8'h00;

  // ==========================================================================
  // status register fields
  localparam int          STAT_WARN_BIT = 0;     // multiplier source out of range
  localparam int          STAT_SRC_BIT  = 1;     // tick comes from trimmed oscillator
  localparam logic [7:0]  STAT_ZERO     = 8'h00;

  // ==========================================================================
  // trim codes, signed field and offset binary code towards the oscillators
  localparam logic [5:0]  TRIM_MAX      = 6'h1f;
  localparam logic [5:0]  TRIM_MIN      = 6'h20;
  localparam logic [5:0]  TRIM_CALIB    = 6'h00;
  localparam logic [5:0]  CODE_MAX      = 6'h3f;
  localparam logic [5:0]  CODE_MIN      = 6'h00;
  localparam logic [5:0]  CODE_CALIB    = 6'h20;

  // ==========================================================================
  // frequencies
  localparam logic [15:0] MULT_MIN_KHZ  = 16'h0fa0; // 4 MHz
  localparam logic [15:0] MULT_MAX_KHZ  = 16'h3e80; // 16 MHz
  localparam int          MID_FREQ_HZ   = 500000;   // medium oscillator tap
  localparam int          LF_CLK_HZ     = 31250;    // low frequency device clock
  localparam int          MID_DIV       = MID_FREQ_HZ / LF_CLK_HZ;
  localparam int          DIV_W         = 8;

endpackage

// ==== hdl/iot_edge_sync.sv ====
// two flop synchroniser with rising edge pulse
// assumes asyncIn is a slow oscillator level from outside the core clock
`timescale 1ns/10ps
module iot_edge_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      rise
);
  import iot_pkg::*;

  logic stage1_r;
  logic stage2_r;
  logic prev_r;
  logic stage1_nxt;
  logic stage2_nxt;
  logic prev_nxt;

  // ==========================================================================
  // next values, the first stage feeds only the second
  always_comb begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
    prev_nxt   = stage2_r;
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      prev_r   <= 1'b0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
      prev_r   <= prev_nxt;
    end
  end

  // one pulse per rising edge of the synchronised level
  assign rise = stage2_r & ~prev_r;

  // ==========================================================================
  // checks
  risePulse_a: assert property (@(posedge core_clk) disable iff (rst)
    rise |=> !rise)
    else $error("edge pulse longer than one cycle");

endmodule

// ==== hdl/iot_trim_code.sv ====
// maps the signed trim field onto a monotonic offset binary oscillator code
// assumes the oscillator raises its frequency as the code rises
`timescale 1ns/10ps
module iot_trim_code (
  input  wire logic [iot_pkg::TRIM_W-1:0] trim,
  output logic      [iot_pkg::TRIM_W-1:0] code
);
  import iot_pkg::*;

  // ==========================================================================
  // inverting the sign bit turns two's complement into offset binary:
  // most negative to all zeros, zero to mid scale, most positive to all ones
  always_comb begin
    code = {~trim[TRIM_W-1], trim[TRIM_W-2:0]};
  end

endmodule

// ==== hdl/iot_internal_osc_tuning.sv ====
// internal oscillator tuning and low frequency source selection
// assumes oscillator inputs are free running levels from outside core_clk
// and the primary frequency word comes from logic on core_clk
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
module iot_internal_osc_tuning #(
  parameter int MID_DIVIDE = iot_pkg::MID_DIV
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [iot_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [iot_pkg::REG_W-1:0]  regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [iot_pkg::REG_W-1:0]  regRdata,
  input  wire logic                       lowFreqOscIn,
  input  wire logic                       midFreqOscIn,
  input  wire logic [15:0]                primaryFreqKhz,
  output logic                            deviceClkTick,
  output logic                            lowFreqSourceSelect,
  output logic                            freqMultiplierEnable,
  output logic      [iot_pkg::TRIM_W-1:0] freqTrimField,
  output logic      [iot_pkg::TRIM_W-1:0] midFreqTrimCode,
  output logic      [iot_pkg::TRIM_W-1:0] highFreqTrimCode,
  output logic                            trimShiftStart,
  output logic                            multiplierRangeWarn
);
  import iot_pkg::*;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MID_DIVIDE - 1);

  // ==========================================================================
  // declarations

  logic [REG_W-1:0]  trimReg_r;
  logic [REG_W-1:0]  trimReg_nxt;
  logic [REG_W-1:0]  rdata_r;
  logic [REG_W-1:0]  rdata_nxt;
  logic              shift_r;
  logic              shift_nxt;
  logic              warn_r;
  logic              warn_nxt;
  logic [TRIM_W-1:0] code_r;
  logic [TRIM_W-1:0] code_nxt;
  logic [DIV_W-1:0]  divCount_r;
  logic [DIV_W-1:0]  divCount_nxt;
  logic              tick_r;
  logic              tick_nxt;
  logic              lowRise;
  logic              midRise;
  logic              midWrap;
  logic              trimWrite;
  logic [REG_W-1:0]  statusWord;

  // ==========================================================================
  // oscillator edge capture

  // low frequency oscillator, reaches the tick path with no trim applied
  iot_edge_sync u_lowSync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (lowFreqOscIn),
    .rise     (lowRise)
  );

  // medium frequency oscillator tap, divided down when selected
  iot_edge_sync u_midSync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (midFreqOscIn),
    .rise     (midRise)
  );

  // ==========================================================================
  // register port

  // decoded write to the tuning register
  assign trimWrite = regWrite && (regAddr == TRIM_OFS);

  // status word shows what the block is doing right now
  always_comb begin
    statusWord                = STAT_ZERO;
    statusWord[STAT_WARN_BIT] = warn_r;
    statusWord[STAT_SRC_BIT]  = trimReg_r[SRC_BIT];
  end

  // next register contents and read data, zero outside the answer cycle
  always_comb begin
    trimReg_nxt = trimReg_r;
    rdata_nxt   = STAT_ZERO;
    if (trimWrite) begin
      trimReg_nxt = regWdata;
    end
    if (regRead) begin
      case (regAddr)
        TRIM_OFS: rdata_nxt = trimReg_r;
        STAT_OFS: rdata_nxt = statusWord;
        default:  rdata_nxt = STAT_ZERO; // unmapped reads as zero
      endcase
    end
  end

  // register port flops, tuning register clears to zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trimReg_r <= TRIM_RESET;
      rdata_r   <= STAT_ZERO;
    end else begin
      trimReg_r <= trimReg_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

  // ==========================================================================
  // field outputs

  // fields drive the source mux, multiplier and trim straight from the flops
  assign lowFreqSourceSelect  = trimReg_r[SRC_BIT];
  assign freqMultiplierEnable = trimReg_r[MULT_BIT];
  assign freqTrimField        = trimReg_r[TRIM_MSB:TRIM_LSB];

  // ==========================================================================
  // trim towards the medium and high oscillators

  // signed field to monotonic analog code
  iot_trim_code u_trimCode (
    .trim (freqTrimField),
    .code (code_nxt)
  );

  // one pulse after each write tells the oscillators to start moving;
  // there is no done indication, software carries on during the shift
  always_comb begin
    shift_nxt = trimWrite;
  end

  // trim code flops, mid scale means factory calibration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      code_r  <= CODE_CALIB;
      shift_r <= 1'b0;
    end else begin
      code_r  <= code_nxt;
      shift_r <= shift_nxt;
    end
  end

  // both trimmed oscillators share one code, the low oscillator gets none
  assign midFreqTrimCode  = code_r;
  assign highFreqTrimCode = code_r;
  assign trimShiftStart   = shift_r;

  // ==========================================================================
  // multiplier source range advice

  // the multiplier follows any primary source; warn outside its design range
  always_comb begin
    warn_nxt = freqMultiplierEnable &&
               ((primaryFreqKhz < MULT_MIN_KHZ) ||
                (primaryFreqKhz > MULT_MAX_KHZ));
  end

  // warning flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      warn_r <= 1'b0;
    end else begin
      warn_r <= warn_nxt;
    end
  end

  assign multiplierRangeWarn = warn_r;

  // ==========================================================================
  // low frequency device clock

  // divider on the medium tap, wraps once per device clock period
  assign midWrap = midRise && (divCount_r == DIV_LAST);

  // next divider value and tick source selection
  always_comb begin
    divCount_nxt = divCount_r;
    if (midRise) begin
      if (divCount_r == DIV_LAST) begin
        divCount_nxt = '0;
      end else begin
        divCount_nxt = divCount_r + DIV_W'(1);
      end
    end
    if (lowFreqSourceSelect) begin
      tick_nxt = midWrap;
    end else begin
      tick_nxt = lowRise;
    end
  end

  // divider and tick flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      divCount_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      divCount_r <= divCount_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign deviceClkTick = tick_r;

  // ==========================================================================
  // checks
  // a synchronous reset clears state while $past still holds pre-reset values,
  // so history based checks skip the first cycle after any reset, except srcLow_a, rdIdle_a and resetZero_a

  fieldMap_a: assert property (@(posedge core_clk) disable iff (rst)
    trimWrite |=> ({lowFreqSourceSelect, freqMultiplierEnable, freqTrimField}
                   == $past(regWdata)))
    else $error("tuning fields do not match written byte");

  readBack_a: assert property (@(posedge core_clk) disable iff (rst)
    (regRead && (regAddr == TRIM_OFS)) |=> (regRdata == $past(trimReg_r)))
    else $error("tuning register read back wrong");

  srcLow_a: assert property (@(posedge core_clk) disable iff (rst)
    deviceClkTick |-> $past(lowFreqSourceSelect ? midWrap : lowRise))
    else $error("device tick from unselected source");

  srcMid_a: assert property (@(posedge core_clk) disable iff (rst)
    (lowFreqSourceSelect && midWrap) |=> deviceClkTick)
    else $error("divided tick missing");

  multOn_a: assert property (@(posedge core_clk) disable iff (rst)
    ($changed(freqMultiplierEnable) && !$past(rst)) |-> $past(trimWrite)
      && (freqMultiplierEnable == $past(regWdata[MULT_BIT])))
    else $error("multiplier enable changed without write");

  rangeWarn_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> (multiplierRangeWarn == ($past(freqMultiplierEnable) &&
      (($past(primaryFreqKhz) < MULT_MIN_KHZ) ||
       ($past(primaryFreqKhz) > MULT_MAX_KHZ)))))
    else $error("multiplier range warning wrong");

  trimMax_a: assert property (@(posedge core_clk) disable iff (rst)
    (!$past(rst) && ($past(freqTrimField) == TRIM_MAX)) |->
      (highFreqTrimCode == CODE_MAX))
    else $error("max trim not highest code");

  trimMin_a: assert property (@(posedge core_clk) disable iff (rst)
    (!$past(rst) && ($past(freqTrimField) == TRIM_MIN)) |->
      (midFreqTrimCode == CODE_MIN))
    else $error("min trim not lowest code");

  trimCalib_a: assert property (@(posedge core_clk) disable iff (rst)
    (!$past(rst) && ($past(freqTrimField) == TRIM_CALIB)) |->
      (highFreqTrimCode == CODE_CALIB))
    else $error("zero trim not calibrated code");

  resetZero_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(rst) |-> (freqTrimField == TRIM_CALIB) && !freqMultiplierEnable)
    else $error("tuning register not zero after reset");

  lowFree_a: assert property (@(posedge core_clk) disable iff (rst)
    (!lowFreqSourceSelect && lowRise) |=> deviceClkTick)
    else $error("trim change disturbed low oscillator tick");

  shiftStart_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> (trimShiftStart == $past(trimWrite)))
    else $error("shift start pulse wrong");

  rdIdle_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(regRead) |-> (regRdata == STAT_ZERO))
    else $error("read data not zero outside answer cycle");

  statusRead_a: assert property (@(posedge core_clk) disable iff (rst)
    (regRead && (regAddr == STAT_OFS)) |=> (regRdata == $past(statusWord)))
    else $error("status read back wrong");

  divWrap_a: assert property (@(posedge core_clk) disable iff (rst)
    midWrap |=> (divCount_r == '0))
    else $error("divider did not wrap");

  // main scenarios
  srcSwitch_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(lowFreqSourceSelect) ##[1:64] deviceClkTick);
  trimTop_c: cover property (@(posedge core_clk) disable iff (rst)
    highFreqTrimCode == CODE_MAX);
  warnOn_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(multiplierRangeWarn));
  readTrim_c: cover property (@(posedge core_clk) disable iff (rst)
    trimWrite ##1 (regRead && (regAddr == TRIM_OFS)));
  lowTick_c: cover property (@(posedge core_clk) disable iff (rst)
    !lowFreqSourceSelect && deviceClkTick);

endmodule

// ==== tb/internal_osc_tuning_tb.sv ====
// self-checking bench for the internal oscillator tuning block
// assumes iot_pkg and the hdl files are compiled first; assertions live in the design
`timescale 1ns/10ps
module internal_osc_tuning_tb;
  import iot_pkg::*;

  // ==========================================================================
  // signals
  localparam int         MID_DIV_TB = 4;  // short divider keeps runs brief
  logic                  core_clk;
  logic                  rst;
  logic [ADDR_W-1:0]     regAddr;
  logic [REG_W-1:0]      regWdata;
  logic                  regWrite;
  logic                  regRead;
  logic [REG_W-1:0]      regRdata;
  logic                  lowFreqOscIn;
  logic                  midFreqOscIn;
  logic [15:0]           primaryFreqKhz;
  logic                  deviceClkTick;
  logic                  lowFreqSourceSelect;
  logic                  freqMultiplierEnable;
  logic [TRIM_W-1:0]     freqTrimField;
  logic [TRIM_W-1:0]     midFreqTrimCode;
  logic [TRIM_W-1:0]     highFreqTrimCode;
  logic                  trimShiftStart;
  logic                  multiplierRangeWarn;
  logic [7:0]            rdVal;
  logic [7:0]            dat;
  logic [7:0]            corners [6] = '{8'h1f, 8'h20, 8'h00, 8'hdf, 8'hff, 8'h40};
  logic [15:0]           freqs [4]   = '{16'h0f9f, 16'h0fa0, 16'h3e80, 16'h3e81};
  logic                  warnExp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int                    errCount    = 0;
  int                    totalChecks = 0;
  int                    tickCnt     = 0;
  int                    tickBase;
  int                    seed;

  // ==========================================================================
  // device under test
  iot_internal_osc_tuning #(.MID_DIVIDE(MID_DIV_TB)) i_dut (
    .core_clk             (core_clk),
    .rst                  (rst),
    .regAddr              (regAddr),
    .regWdata             (regWdata),
    .regWrite             (regWrite),
    .regRead              (regRead),
    .regRdata             (regRdata),
    .lowFreqOscIn         (lowFreqOscIn),
    .midFreqOscIn         (midFreqOscIn),
    .primaryFreqKhz       (primaryFreqKhz),
    .deviceClkTick        (deviceClkTick),
    .lowFreqSourceSelect  (lowFreqSourceSelect),
    .freqMultiplierEnable (freqMultiplierEnable),
    .freqTrimField        (freqTrimField),
    .midFreqTrimCode      (midFreqTrimCode),
    .highFreqTrimCode     (highFreqTrimCode),
    .trimShiftStart       (trimShiftStart),
    .multiplierRangeWarn  (multiplierRangeWarn)
  );

  // ==========================================================================
  // clock and tick counting
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // counts device clock pulses seen on each rising edge
  always @(posedge core_clk) begin
    if (deviceClkTick === 1'b1) tickCnt <= tickCnt + 1;
  end

  // ==========================================================================
  // helpers
  function automatic logic [5:0] expCode(input logic [5:0] t);
    return {~t[5], t[4:0]};  // signed trim onto rising offset code
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // writes the tuning register and checks its field outputs, shift pulse, both trim codes and read back
  task automatic tuneChk(input logic [7:0] d);
    logic [7:0] r;
    wr(TRIM_OFS, d);
    chk("srcSel", {7'h0, lowFreqSourceSelect}, {7'h0, d[SRC_BIT]});
    chk("multEn", {7'h0, freqMultiplierEnable}, {7'h0, d[MULT_BIT]});
    chk("trimField", {2'h0, freqTrimField}, {2'h0, d[5:0]});
    chk("shiftStart", {7'h0, trimShiftStart}, 8'h01);
    @(posedge core_clk);
    #1;
    chk("shiftEnd", {7'h0, trimShiftStart}, 8'h00);
    chk("midCode", {2'h0, midFreqTrimCode}, {2'h0, expCode(d[5:0])});
    chk("highCode", {2'h0, highFreqTrimCode}, {2'h0, expCode(d[5:0])});
    rd(TRIM_OFS, r);
    chk("readBack", r, d);
  endtask

  // oscillator rises, each level held four core cycles, then count ticks
  task automatic tickRun(input logic useMid, input int n, input int expTicks);
    tickBase = tickCnt;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      if (useMid) midFreqOscIn <= 1'b1;
      else lowFreqOscIn <= 1'b1;
      repeat (4) @(posedge core_clk);
      midFreqOscIn <= 1'b0;
      lowFreqOscIn <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    #1;
    chk("tickCount", 8'(tickCnt - tickBase), 8'(expTicks));
  endtask

  task automatic giveVerdict;
    if (errCount == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    giveVerdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed           = 43636;
    rst            = 1'b1;
    regAddr        = 4'h0;
    regWdata       = 8'h00;
    regWrite       = 1'b0;
    regRead        = 1'b0;
    lowFreqOscIn   = 1'b0;
    midFreqOscIn   = 1'b0;
    primaryFreqKhz = 16'h1f40;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("rstCode", {2'h0, midFreqTrimCode}, {2'h0, CODE_CALIB});
    rd(TRIM_OFS, rdVal);
    chk("rstValue", rdVal, TRIM_RESET);
    // corner codes then random codes
    foreach (corners[i]) tuneChk(corners[i]);
    for (int i = 0; i < 20; i++) begin
      dat = 8'($random(seed));
      tuneChk(dat);
    end
    // writes elsewhere are ignored, unmapped reads give zero
    wr(STAT_OFS, 8'hff);
    chk("noShift", {7'h0, trimShiftStart}, 8'h00);
    rd(TRIM_OFS, rdVal);
    chk("keptValue", rdVal, dat);
    rd(4'h5, rdVal);
    chk("unmapped", rdVal, 8'h00);
    // multiplier acts on every source, range only warns
    tuneChk(8'h40);
    foreach (freqs[i]) begin
      @(posedge core_clk);
      primaryFreqKhz <= freqs[i];
      repeat (2) @(posedge core_clk);
      #1;
      chk("rangeWarn", {7'h0, multiplierRangeWarn}, {7'h0, warnExp[i]});
      chk("multStays", {7'h0, freqMultiplierEnable}, 8'h01);
    end
    rd(STAT_OFS, rdVal);
    chk("statWarn", rdVal, 8'h01);
    tuneChk(8'h80);
    repeat (2) @(posedge core_clk);
    #1;
    chk("warnOff", {7'h0, multiplierRangeWarn}, 8'h00);
    rd(STAT_OFS, rdVal);
    chk("statSrc", rdVal, 8'h02);
    // device clock from trimmed oscillator, then from low oscillator
    tickRun(1'b1, 8, 8 / MID_DIV_TB);
    tickRun(1'b0, 5, 0);
    tuneChk(8'h00);
    tickRun(1'b0, 5, 5);
    tickRun(1'b1, 8, 0);
    // trim changes leave the low oscillator path untouched
    for (int i = 0; i < 3; i++) begin
      tuneChk(8'($random(seed)) & 8'h3f);
      tickRun(1'b0, 1, 1);
    end
    // reset in mid run returns to calibrated trim
    wr(TRIM_OFS, 8'hdf);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("rstField", {2'h0, freqTrimField}, 8'h00);
    chk("rstSel", {6'h0, lowFreqSourceSelect, freqMultiplierEnable}, 8'h00);
    chk("rstHigh", {2'h0, highFreqTrimCode}, {2'h0, CODE_CALIB});
    rd(TRIM_OFS, rdVal);
    chk("rstRead", rdVal, TRIM_RESET);
    tuneChk(8'h5f);
    // read straight after write returns the new value
    @(posedge core_clk);
    regAddr  <= TRIM_OFS;
    regWdata <= 8'h21;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    @(posedge core_clk);
    regRead  <= 1'b0;
    #1;
    chk("b2bRead", regRdata, 8'h21);
    giveVerdict();
  end
endmodule
